//--- fma_pkg.sv
// Constants, types and state layout for the flash access control block
package fma_pkg;
  // ---------------------------------------------------------------------------
  // Register map (byte addresses on the Avalon-MM slave)
  // ---------------------------------------------------------------------------
  localparam logic [3:0] OFS_MAP    = 4'h0;
  localparam logic [3:0] OFS_ID_MAIN = 4'h4;
  localparam logic [3:0] OFS_ID_SEC  = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  // Mapping register fields and masks
  localparam int MAP_SRAM_FETCH = 0;
  localparam int MAP_SEC_FETCH  = 1;
  localparam int MAP_MAIN_FETCH = 2;
  localparam int MAP_SEC_READ   = 3;
  localparam int MAP_MAIN_READ  = 4;
  localparam int MAP_PORT_SIX   = 7;
  localparam logic [7:0] MAP_WR_MASK = 8'h9f;
  localparam logic [7:0] MAP_RST     = 8'h00;
  // Identification codes
  localparam logic [3:0] MAIN_2MBIT = 4'h4;
  localparam logic [3:0] MAIN_8MBIT = 4'h5;
  localparam logic [3:0] SRAM_NONE  = 4'h0;
  localparam logic [3:0] SRAM_16K   = 4'h1;
  localparam logic [3:0] SRAM_64K   = 4'h3;
  localparam logic [3:0] SEC_NONE   = 4'h0;
  localparam logic [3:0] SEC_256K   = 4'h2;
  localparam logic [1:0] SEC_FLASH  = 2'h0;
  // Sector geometry
  localparam int MAIN_SECTORS = 8;
  localparam int SEC_SECTORS  = 4;
  localparam int MAIN_SECT_KB = 64;
  localparam int SEC_SECT_KB  = 8;
  localparam int TERMS        = 3;
  // Instruction bytes and addresses
  localparam logic [11:0] UNL_ADDR1 = 12'h555;
  localparam logic [11:0] UNL_ADDR2 = 12'haaa;
  localparam logic [7:0]  UNL_DATA1 = 8'haa;
  localparam logic [7:0]  UNL_DATA2 = 8'h55;
  localparam logic [7:0]  CMD_PROG  = 8'ha0;
  localparam logic [7:0]  CMD_ERASE = 8'h80;
  localparam logic [7:0]  CMD_ID    = 8'h90;
  localparam logic [7:0]  CMD_SECT  = 8'h30;
  localparam logic [7:0]  CMD_BULK  = 8'h10;
  localparam logic [7:0]  CMD_SUSP  = 8'hb0;
  localparam logic [7:0]  CMD_RESET = 8'hf0;
  localparam logic [1:0]  ID_ADDR   = 2'h1;
  localparam logic [1:0]  PROT_ADDR = 2'h2;
  localparam logic [7:0]  PROT_YES  = 8'h01;
  localparam logic [7:0]  PROT_NO   = 8'h00;
  // Timing
  localparam int CLK_MHZ   = 40;
  localparam int GAP_US    = 80;
  localparam int GAP_CYC   = GAP_US * CLK_MHZ;
  localparam int PROG_US   = 14;
  localparam int PROG_CYC  = PROG_US * CLK_MHZ;
  localparam int ERASE_MS  = 1000;
  localparam int ERASE_CYC = ERASE_MS * 1000 * CLK_MHZ;
  localparam int CNT_W     = 26;
  // Instruction sequencer states
  typedef enum logic [8:0] {
    ST_READ = 9'h001, ST_UNL1 = 9'h002, ST_UNL2 = 9'h004,
    ST_PROG = 9'h008, ST_ERS0 = 9'h010, ST_ERS1 = 9'h020,
    ST_ERS2 = 9'h040, ST_EWIN = 9'h080, ST_ID   = 9'h100
  } fma_seq_e;
  // Host bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic        fetch;
  } fma_host_s;
  // Whole state of the block
  typedef struct packed {
    logic [7:0]              map;
    logic                    strap_done;
    logic                    ack;
    logic [31:0]             rdata;
    fma_seq_e                seq;
    logic                    tgt_main;
    logic [CNT_W-1:0]        gap;
    logic                    busy;
    logic                    erasing;
    logic                    susp;
    logic [CNT_W-1:0]        op_cnt;
    logic [MAIN_SECTORS-1:0] ers_main;
    logic [SEC_SECTORS-1:0]  ers_sec;
    logic                    prog;
    logic                    erase;
    logic [15:0]             prog_addr;
    logic [7:0]              prog_data;
    logic [7:0]              host_rdata;
  } fma_state_s;
endpackage : fma_pkg

//--- fma_flash_access.sv
// Flash access control: memory mapping, size identification, sector decode and instruction sequencing
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module fma_flash_access #(
  parameter logic [3:0] MAIN_SIZE   = 4'h4,
  parameter logic [3:0] SRAM_SIZE   = 4'h3,
  parameter logic [3:0] SEC_SIZE    = 4'h2,
  parameter logic [7:0] MAIN_ID     = 8'h5a,   // Arbitrary identifier value
  parameter int         ERASE_TIME  = 40000000
) (
  // Clock and reset
  input  wire logic                                 sys_clk_i,
  input  wire logic                                 rst_n_i,
  // Avalon-MM register slave
  input  wire logic [3:0]                           avs_address_i,
  input  wire logic                                 avs_read_i,
  input  wire logic                                 avs_write_i,
  input  wire logic [31:0]                          avs_writedata_i,
  input  wire logic [3:0]                           avs_byteenable_i,
  output logic [31:0]                               avs_readdata_o,
  output logic                                      avs_waitrequest_o,
  // Configuration straps
  input  wire logic                                 xa_mode_i,
  input  wire logic [4:1]                           cfg_map_i,
  input  wire logic                                 half_defined_i,
  input  wire logic                                 ready_busy_cfg_i,
  // Host parallel bus and decode logic terms
  input  wire fma_pkg::fma_host_s                   host_i,
  input  wire logic                                 page_bit_four_i,
  input  wire logic [fma_pkg::TERMS*fma_pkg::MAIN_SECTORS-1:0] main_terms_i,
  input  wire logic [fma_pkg::TERMS*fma_pkg::SEC_SECTORS-1:0]  sec_terms_i,
  input  wire logic                                 sram_sel_i,
  input  wire logic [fma_pkg::MAIN_SECTORS-1:0]     main_prot_i,
  input  wire logic [fma_pkg::SEC_SECTORS-1:0]      sec_prot_i,
  output logic [7:0]                                host_rdata_o,
  // Memory strobes
  output logic [fma_pkg::MAIN_SECTORS-1:0]          main_sector_selects_o,
  output logic [fma_pkg::SEC_SECTORS-1:0]           secondary_sector_selects_o,
  output logic                                      main_access_o,
  output logic                                      sec_access_o,
  output logic                                      sram_access_o,
  output logic                                      main_a15_o,
  // Array operations
  input  wire logic [7:0]                           array_rdata_i,
  output logic                                      array_prog_o,
  output logic                                      array_prog_main_o,
  output logic [15:0]                               array_prog_addr_o,
  output logic [7:0]                                array_prog_data_o,
  output logic                                      array_erase_o,
  output logic [fma_pkg::MAIN_SECTORS-1:0]          array_erase_main_o,
  output logic [fma_pkg::SEC_SECTORS-1:0]           array_erase_sec_o,
  // Pins
  output logic                                      ready_busy_pin_o,
  output logic                                      ready_busy_oe_n_o,
  output logic                                      port_six_peripheral_enable_o
);
  import fma_pkg::*;

  // ---------------------------------------------------------------------------
  // Sector decode
  // ---------------------------------------------------------------------------
  // eight main sectors, four secondary sectors
  logic [MAIN_SECTORS-1:0] msel;
  logic [SEC_SECTORS-1:0]  ssel;
  always_comb begin
    for (int i = 0; i < MAIN_SECTORS; i++) begin
      msel[i] = |main_terms_i[i*TERMS +: TERMS];
    end
    for (int j = 0; j < SEC_SECTORS; j++) begin
      ssel[j] = |sec_terms_i[j*TERMS +: TERMS];
    end
  end
  assign main_sector_selects_o      = msel;
  assign secondary_sector_selects_o = ssel;

  fma_state_s q;
  fma_state_s d;

  logic any_main;
  logic any_sec;
  logic fetch_sram_ok;
  logic fetch_sec_ok;
  logic fetch_main_ok;
  logic read_sec_ok;
  logic read_main_ok;
  assign any_main = |msel;
  assign any_sec  = |ssel;
  // outside the separate-space mode every path stays open
  assign fetch_sram_ok = !xa_mode_i || q.map[MAP_SRAM_FETCH];
  assign fetch_sec_ok  = !xa_mode_i || q.map[MAP_SEC_FETCH];
  assign fetch_main_ok = !xa_mode_i || q.map[MAP_MAIN_FETCH];
  assign read_sec_ok   = !xa_mode_i || q.map[MAP_SEC_READ];
  assign read_main_ok  = !xa_mode_i || q.map[MAP_MAIN_READ];

  // ---------------------------------------------------------------------------
  // Strobe gating
  // ---------------------------------------------------------------------------
  // fetch strobe gated per memory; data read gated per flash
  assign sram_access_o = sram_sel_i && ((host_i.fetch && fetch_sram_ok) || host_i.rd || host_i.wr);
  assign sec_access_o  = any_sec && ((host_i.fetch && fetch_sec_ok) || (host_i.rd && read_sec_ok));
  assign main_access_o = any_main && ((host_i.fetch && fetch_main_ok) || (host_i.rd && read_main_ok));
  // half-block select on A15; all sectors at once, not while erasing
  assign main_a15_o = (half_defined_i && !(q.busy && q.erasing)) ? page_bit_four_i : host_i.addr[15];

  // ---------------------------------------------------------------------------
  // Register and sequencer state update
  // ---------------------------------------------------------------------------
  logic        fwr;
  logic [11:0] a12;
  logic [7:0]  wd;
  logic        tgt_prot;
  logic        bus_req;
  logic [31:0] reg_rd;
  assign fwr     = host_i.wr && (any_main || any_sec);
  assign a12     = host_i.addr[11:0];
  assign wd      = host_i.wdata;
  assign bus_req = avs_read_i || avs_write_i;
  // protection of the sector now addressed
  assign tgt_prot = (any_main && |(msel & main_prot_i)) || (!any_main && |(ssel & sec_prot_i));

  // Register read mux; unmapped offsets read zero
  always_comb begin
    reg_rd = 32'h0000_0000;
    unique case (avs_address_i)
      OFS_MAP:     reg_rd[7:0] = q.map;
      // main size low nibble; SRAM size high nibble
      OFS_ID_MAIN: reg_rd[7:0] = {SRAM_SIZE, MAIN_SIZE};
      OFS_ID_SEC:  reg_rd[7:0] = {2'h0, SEC_FLASH, SEC_SIZE};
      OFS_STATUS:  reg_rd[3:0] = {xa_mode_i, q.seq == ST_ID, q.susp, q.busy};
      default:     reg_rd = 32'h0000_0000;
    endcase
  end

  always_comb begin
    d       = q;
    d.ack   = bus_req && !q.ack;
    d.prog  = 1'b0;
    d.erase = 1'b0;
    // stored configuration caught once after release
    if (!q.strap_done) begin
      d.strap_done = 1'b1;
      d.map[4:1]   = cfg_map_i;
    end
    // Bus slave: one wait state, then the answer; ID registers ignore writes
    if (bus_req && !q.ack) begin
      d.rdata = reg_rd;
      if (avs_write_i && avs_address_i == OFS_MAP && avs_byteenable_i[0]) begin
        d.map = avs_writedata_i[7:0] & MAP_WR_MASK;
      end
    end
    // Embedded operation timer
    if (q.busy && !q.susp) begin
      if (q.op_cnt == '0) begin
        d.busy    = 1'b0;
        d.erasing = 1'b0;
      end else begin
        d.op_cnt = q.op_cnt - 1'b1;
      end
    end
    if (q.seq != ST_READ && q.seq != ST_ID) begin
      if (q.gap == '0) begin
        d.seq = ST_READ;
        // Sector list closes: erase of the collected sectors starts
        if (q.seq == ST_EWIN) begin
          d.erase   = 1'b1;
          d.busy    = 1'b1;
          d.erasing = 1'b1;
          d.op_cnt  = CNT_W'(ERASE_TIME);
        end
      end else begin
        d.gap = q.gap - 1'b1;
      end
    end
    // flash writes feed the sequencer; a write in ST_PROG reaches the array as a program, a bulk erase write in ST_ERS2 as an erase
    if (fwr) begin
      d.gap = CNT_W'(GAP_CYC - 1);
      d.seq = ST_READ;
      unique case (q.seq)
        ST_READ, ST_ID: begin
          if (wd == UNL_DATA1 && a12 == UNL_ADDR1) begin
            d.seq      = ST_UNL1;
            d.tgt_main = any_main;
          end else if (wd == CMD_SUSP && q.busy && q.erasing && !q.susp && q.op_cnt != '0) begin
            // suspend a running erase; one that ends this cycle cannot be held
            d.susp = 1'b1;
          end else if (wd == CMD_SECT && q.susp) begin
            d.susp = 1'b0;
          end else if (q.seq == ST_ID && wd != CMD_RESET) begin
            d.seq = ST_ID;
          end
        end
        ST_UNL1: begin
          if (wd == UNL_DATA2 && a12 == UNL_ADDR2) begin
            d.seq = ST_UNL2;
          end
        end
        ST_UNL2: begin
          if (a12 == UNL_ADDR1) begin
            unique case (wd)
              CMD_PROG:  d.seq = ST_PROG;
              CMD_ERASE: d.seq = q.susp ? ST_READ : ST_ERS0;
              CMD_ID:    d.seq = ST_ID;
              default:   d.seq = ST_READ;
            endcase
          end
        end
        ST_PROG: begin
          // refuse protected target; one byte per program
          if (!tgt_prot && (!q.busy || (q.susp && !(|(msel & q.ers_main)) && !(|(ssel & q.ers_sec))))) begin
            d.prog      = 1'b1;
            d.prog_addr = host_i.addr;
            d.prog_data = wd;
            d.tgt_main  = any_main;
            d.busy      = 1'b1;
            d.op_cnt    = CNT_W'(PROG_CYC - 1);
          end
        end
        ST_ERS0: if (wd == UNL_DATA1 && a12 == UNL_ADDR1) d.seq = ST_ERS1;
        ST_ERS1: if (wd == UNL_DATA2 && a12 == UNL_ADDR2) d.seq = ST_ERS2;
        ST_ERS2, ST_EWIN: begin
          if (wd == CMD_SECT && !q.busy) begin
            // protected sectors drop out of the list
            d.seq      = ST_EWIN;
            d.ers_main = (q.seq == ST_ERS2 ? '0 : q.ers_main) | (msel & ~main_prot_i);
            d.ers_sec  = (q.seq == ST_ERS2 ? '0 : q.ers_sec) | (ssel & ~sec_prot_i);
          end else if (q.seq == ST_ERS2 && wd == CMD_BULK && a12 == UNL_ADDR1 && !q.busy) begin
            d.ers_main = q.tgt_main ? ~main_prot_i : '0;
            d.ers_sec  = q.tgt_main ? '0 : ~sec_prot_i;
            d.erase    = 1'b1;
            d.busy     = 1'b1;
            d.erasing  = 1'b1;
            d.op_cnt   = CNT_W'(ERASE_TIME);
          end
        end
        default: d.seq = ST_READ;
      endcase
    end
    // ROM-like read data, or identification words in ID mode
    d.host_rdata = array_rdata_i;
    if (q.seq == ST_ID && (any_main || any_sec)) begin
      if (a12[1:0] == ID_ADDR && q.tgt_main) begin
        d.host_rdata = MAIN_ID;
      end else if (a12[1:0] == PROT_ADDR) begin
        d.host_rdata = tgt_prot ? PROT_YES : PROT_NO;
      end
    end
  end

  // reset clears the map, straps are caught after release
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q            <= '0;
      q.map        <= MAP_RST;
      q.seq        <= ST_READ;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign avs_waitrequest_o  = bus_req && !q.ack;
  assign avs_readdata_o     = q.rdata;
  assign host_rdata_o       = q.host_rdata;
  assign array_prog_o       = q.prog;
  assign array_prog_main_o  = q.tgt_main;
  assign array_prog_addr_o  = q.prog_addr;
  assign array_prog_data_o  = q.prog_data;
  assign array_erase_o      = q.erase;
  assign array_erase_main_o = q.ers_main;
  assign array_erase_sec_o  = q.ers_sec;
  // busy low while an operation runs; a suspended erase reads ready
  assign ready_busy_pin_o   = !(q.busy && !q.susp);
  assign ready_busy_oe_n_o  = !ready_busy_cfg_i;
  // peripheral mode of the sixth port
  assign port_six_peripheral_enable_o = q.map[MAP_PORT_SIX];

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  fetch_gate_a: assert property (xa_mode_i && !q.map[MAP_MAIN_FETCH] && !host_i.rd |-> !main_access_o)
    else $error("main fetch passed with bit clear");
  read_gate_a: assert property (xa_mode_i && !q.map[MAP_SEC_READ] && !host_i.fetch |-> !sec_access_o)
    else $error("secondary read passed with bit clear");
  mode_open_a: assert property (!xa_mode_i && host_i.rd && any_main |-> main_access_o)
    else $error("map bits acted outside mode");
  strap_load_a: assert property ($rose(q.strap_done) |-> q.map[4:1] == $past(cfg_map_i) && !q.map[0] && !q.map[7])
    else $error("mapping not loaded at reset");
  id_ro_a: assert property (avs_write_i && avs_address_i == OFS_ID_MAIN |=> $stable(q.map))
    else $error("write to ID register changed state");
  busy_pin_a: assert property ($rose(q.prog) |-> !ready_busy_pin_o [*4])
    else $error("ready pin not busy during program");
  prot_refuse_a: assert property (fwr && q.seq == ST_PROG && tgt_prot |=> !q.prog)
    else $error("program to protected sector");
  gap_drop_a: assert property (q.seq == ST_UNL1 && q.gap == '0 && !fwr |=> q.seq == ST_READ)
    else $error("sequence survived timeout");
  half_sel_a: assert property (half_defined_i && !q.busy |-> main_a15_o == page_bit_four_i)
    else $error("half-block select not applied");
  unlock_a: assert property (q.seq == ST_READ && fwr && wd != UNL_DATA1 |=> q.seq != ST_UNL1)
    else $error("unlock entered without AAh");
endmodule : fma_flash_access
`default_nettype wire

//--- fma_flash_access_end_marker_none.sv
// Intentionally empty compile unit
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

//--- fma_host_model.sv
// Host microcontroller bus model for the flash access bench
`timescale 1ns/100ps
`default_nettype none
module fma_host_model (
  // Clock
  input  wire logic             clk_i,
  // Host bus and returned data
  output var fma_pkg::fma_host_s host_o,
  input  wire logic [7:0]       rdata_i
);
  import fma_pkg::*;

  // Bus idles with no strobe active
  initial host_o = '0;

  // Single byte write
  // The data line shows the inverse once released, so stale data never looks valid
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    host_o <= {a, d, 3'b100};
    @(posedge clk_i);
    host_o.wr    <= 1'b0;
    host_o.wdata <= ~d;
  endtask

  task automatic cmd(input logic [7:0] c);
    wr({4'h0, UNL_ADDR1}, UNL_DATA1);
    wr({4'h0, UNL_ADDR2}, UNL_DATA2);
    wr({4'h0, UNL_ADDR1}, c);
  endtask

  // Fetch or read strobe held until the next call
  task automatic bus(input logic [15:0] a, input logic f, input logic r);
    @(posedge clk_i);
    host_o <= {a, 8'h00, 1'b0, r, f};
  endtask

  // Read data lands one cycle after the address
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    bus(a, 1'b0, 1'b1);
    @(posedge clk_i);
    @(negedge clk_i);
    d = rdata_i;
  endtask
endmodule // fma_host_model
`default_nettype wire

//--- fma_flash_access_tb_top.sv
// Self-checking bench for the flash access control block
`timescale 1ns/100ps
`default_nettype none
module fma_flash_access_tb_top;
  import fma_pkg::*;
  localparam logic [7:0] ID_VAL = 8'h3e;  // Arbitrary identifier value
  logic clk = 1'b0, rst_n = 1'b0, avs_rd, avs_wr, wait_o, xa, half, page, ssel;
  logic macc, sacc, racc, a15, prog, pmain, ers, rb, rboe, p6, rbcfg;
  logic [3:0] adr, cfg, ssel_o;
  logic [31:0] wdat, rdat;
  logic [23:0] mterm;
  logic [11:0] sterm;
  logic [15:0] paddr;
  logic [7:0] mprot, hrd, d, ard, msel, pdata, emain;
  fma_host_s host;
  int n_mismatch = 0, n_compared = 0, n_prog = 0, n_ers = 0;
  // Rows: map, xa, fetch, rd, sram select | main, sec, sram, port six
  logic [15:0] rows [9] = '{16'h01d2, 16'h02d4, 16'h04d8, 16'h08a4, 16'h10a8,
                            16'h18c0, 16'h07a0, 16'h005e, 16'h80d1};

  always #12.5 clk = ~clk;
  // Array contents follow the address so reads are predictable
  assign ard = host.addr[7:0] ^ 8'h3c;
  always @(posedge clk) begin
    if (prog === 1'b1) n_prog <= n_prog + 1;
    if (ers === 1'b1) n_ers <= n_ers + 1;
  end

  fma_host_model u_host (.clk_i(clk), .host_o(host), .rdata_i(hrd));
  fma_flash_access #(.MAIN_SIZE(MAIN_8MBIT), .SRAM_SIZE(SRAM_16K), .SEC_SIZE(SEC_256K),
    .MAIN_ID(ID_VAL), .ERASE_TIME(50)) u_dut (
    .sys_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr), .avs_read_i(avs_rd),
    .avs_write_i(avs_wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_o), .xa_mode_i(xa), .cfg_map_i(cfg), .half_defined_i(half),
    .ready_busy_cfg_i(rbcfg), .host_i(host), .page_bit_four_i(page), .main_terms_i(mterm),
    .sec_terms_i(sterm), .sram_sel_i(ssel), .main_prot_i(mprot), .sec_prot_i(4'h0),
    .host_rdata_o(hrd), .main_sector_selects_o(msel), .secondary_sector_selects_o(ssel_o),
    .main_access_o(macc), .sec_access_o(sacc), .sram_access_o(racc), .main_a15_o(a15),
    .array_rdata_i(ard), .array_prog_o(prog), .array_prog_main_o(pmain),
    .array_prog_addr_o(paddr), .array_prog_data_o(pdata), .array_erase_o(ers),
    .array_erase_main_o(emain), .array_erase_sec_o(), .ready_busy_pin_o(rb),
    .ready_busy_oe_n_o(rboe), .port_six_peripheral_enable_o(p6));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic timeout();
    n_mismatch++;
    results();
  endtask
  // Avalon transfer held until waitrequest is seen low; upper lanes written as zero
  task automatic avs(input logic w, input logic [3:0] a, input logic [7:0] wd, output logic [7:0] q);
    int i;
    @(posedge clk);
    avs_wr <= w;
    avs_rd <= !w;
    adr <= a;
    wdat <= {24'h0, wd};
    i = 0;
    // Waitrequest and read data are both taken at the rising edge that ends the transfer
    do begin
      @(posedge clk);
      i++;
    end while (wait_o !== 1'b0 && i < 20);
    if (wait_o !== 1'b0) timeout();
    q = rdat[7:0];
    avs_wr <= 1'b0;
    avs_rd <= 1'b0;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    logic [7:0] q;
    avs(1'b1, a, v, q);
  endtask
  task automatic rdreg(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] q;
    avs(1'b0, a, 8'h00, q);
    check(q, e);
  endtask
  // Pin must come back ready within a bounded wait
  task automatic wait_ready(input int lim);
    for (int i = 0; i < lim && rb !== 1'b1; i++) @(negedge clk);
    if (rb !== 1'b1) timeout();
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    timeout();
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    {avs_rd, avs_wr, xa, half, page, ssel} = '0;
    adr = 4'h0;
    wdat = '0;
    cfg = 4'b1010;
    mterm = 24'h1;
    sterm = 12'h1;
    mprot = '0;
    rbcfg = 1'b1;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rdreg(OFS_MAP, 8'h14);
    check({rb, rboe, p6}, 3'b100);
    foreach (rows[k]) begin
      wreg(OFS_MAP, rows[k][15:8]);
      xa <= rows[k][7];
      ssel <= rows[k][4];
      u_host.bus(16'h0100, rows[k][6], rows[k][5]);
      @(negedge clk);
      check({macc, sacc, racc, p6}, rows[k][3:0]);
    end
    u_host.bus(16'h0000, 1'b0, 1'b0);
    wreg(OFS_MAP, 8'h9f);
    rdreg(OFS_MAP, MAP_WR_MASK);
    rdreg(OFS_ID_MAIN, {SRAM_16K, MAIN_8MBIT});
    rdreg(OFS_ID_SEC, {2'b00, SEC_FLASH, SEC_256K});
    wreg(OFS_ID_MAIN, 8'h00);
    wreg(OFS_ID_SEC, 8'h00);
    rdreg(OFS_ID_MAIN, {SRAM_16K, MAIN_8MBIT});
    rdreg(OFS_ID_SEC, {2'b00, SEC_FLASH, SEC_256K});
    rdreg(4'h2, 8'h00);
    for (int k = 0; k < 24; k++) begin
      @(posedge clk);
      mterm <= 24'h1 << k;
      sterm <= 12'h1 << (k % 12);
      @(negedge clk);
      check({msel, ssel_o}, {8'h1 << (k / 3), 4'h1 << ((k % 12) / 3)});
    end
    u_host.bus(16'h0000, 1'b1, 1'b0);
    half <= 1'b1;
    page <= 1'b1;
    @(negedge clk);
    check(a15, 1'b1);
    u_host.bus(16'h8000, 1'b1, 1'b0);
    page <= 1'b0;
    mterm <= 24'h1;
    @(negedge clk);
    check(a15, 1'b0);
    u_host.bus(16'h8000, 1'b1, 1'b0);
    half <= 1'b0;
    @(negedge clk);
    check(a15, 1'b1);
    u_host.wr(16'h0123, 8'h5c);
    u_host.cmd(CMD_PROG);
    u_host.wr(16'h0123, 8'h5c);
    repeat (2) @(negedge clk);
    check(n_prog, 1);
    check({pmain, paddr, pdata}, {1'b1, 16'h0123, 8'h5c});
    check(rb, 1'b0);
    rdreg(OFS_STATUS, 8'h09);
    wait_ready(1000);
    u_host.rd(16'h0123, d);
    check(d, 8'h1f);
    mprot <= 8'h01;
    u_host.cmd(CMD_PROG);
    u_host.wr(16'h0200, 8'h11);
    repeat (2) @(negedge clk);
    check(n_prog, 1);
    u_host.cmd(CMD_ID);
    u_host.rd(16'h0001, d);
    check(d, ID_VAL);
    u_host.rd(16'h0002, d);
    check(d, PROT_YES);
    u_host.wr(16'h0000, CMD_RESET);
    u_host.rd(16'h0123, d);
    check(d, 8'h1f);
    mprot <= 8'h00;
    u_host.wr(16'h0555, UNL_DATA1);
    u_host.wr(16'h0aaa, 8'h12);
    u_host.wr(16'h0555, CMD_PROG);
    u_host.wr(16'h0300, 8'h22);
    u_host.wr(16'h0555, UNL_DATA1);
    u_host.wr(16'h0aaa, UNL_DATA2);
    repeat (3300) @(posedge clk);
    u_host.wr(16'h0555, CMD_PROG);
    u_host.wr(16'h0300, 8'h22);
    repeat (2) @(negedge clk);
    check(n_prog, 1);
    u_host.cmd(CMD_ERASE);
    u_host.cmd(CMD_BULK);
    half <= 1'b1;
    page <= 1'b1;
    repeat (2) @(negedge clk);
    check({n_ers[7:0], emain, rb, a15}, {8'h01, 8'hff, 1'b0, 1'b0});
    wait_ready(200);
    // Sector erase of sectors 0 and 1 with sector 0 protected, then suspend and resume
    mprot <= 8'h01;
    mterm <= 24'h9;
    u_host.cmd(CMD_ERASE);
    u_host.wr(16'h0555, UNL_DATA1);
    u_host.wr(16'h0aaa, UNL_DATA2);
    u_host.wr(16'h0000, CMD_SECT);
    repeat (3210) @(negedge clk);
    check({n_ers[7:0], emain, rb}, {8'h02, 8'h02, 1'b0});
    u_host.wr(16'h0000, CMD_SUSP);
    rdreg(OFS_STATUS, 8'h0b);
    check(rb, 1'b1);
    u_host.wr(16'h0000, CMD_SECT);
    @(negedge clk);
    check(rb, 1'b0);
    wait_ready(200);
    wreg(OFS_MAP, 8'h81);
    cfg <= 4'b0101;
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rdreg(OFS_MAP, 8'h0a);
    check(p6, 1'b0);
    rbcfg <= 1'b0;
    @(negedge clk);
    check(rboe, 1'b1);
    results();
  end
endmodule // fma_flash_access_tb_top
`default_nettype wire
